// ===== alc_line_adapter.sv
// Async line adapter: APB command registers, baud generators, serial framing
//
// Local design decisions: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none

// Operation
// RULE1: Speed field bits are inverted, read with top bit as MSB, plus one.
// RULE2: Bit rate is selected reference divided by sixteen times that value.
// RULE3: Range 0101 all ones gives 9600; range 1010 all zeros gives 75.
// RULE4: Range codes pick the 9.6k, 19.2k, 153.6k or special reference.
// RULE5: Receive and transmit rates are set independently.
// RULE6: Receiver tolerates forty percent bit distortion across a character.
// RULE7: Word three header 101 holds parity, length, stop, echo, loopback.
// RULE8: Parity select one means even parity, zero means odd.
// RULE9: Parity disable clear checks and adds parity; set skips both.
// RULE10: Length codes 00,10,01,11 give 5 to 8 data bits, plus parity.
// RULE11: Stop select gives two stop bits, 1.5 for five bits, else one.
// RULE12: Echo mode resends every received line bit while still receiving.
// RULE13: Loopback ties transmit data, request and terminal ready to inputs.
// RULE14: Loopback feeds local, secondary and busy lines back; modem ignored.
// RULE15: Word four header 101 holds receive and transmit speed codes.
// RULE16: Clear to send with output on and request raises first demand.
// RULE17: Each holding buffer to shifter move raises a new demand.
// RULE18: Restraint from the modem suppresses demands until it ends.
// RULE19: Controller answers each demand with one character.
// RULE20: Controller clears with zero commands then briefly enables supervision.
// RULE21: First supervision enable reports power-up status, then clears it.
// RULE22: Received characters are delivered only while receive is enabled.
// RULE23: Status is reported on carrier detect and data set ready rising.
// RULE24: Demands only while output on and commands one and two nonzero.
module alc_line_adapter
    import alc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [3:0] refTick,
    input wire logic rxdIn,
    input wire alc_mdm_in_type mdmIn,
    output logic txdOut,
    output alc_mdm_out_type mdmOut
);
    // ----------------------------------------
    // Functions
    // ----------------------------------------
    function automatic logic [4:0] speedDiv(input logic [3:0] f);
        speedDiv = 5'({1'b0, ~f}) + 5'h01;
    endfunction : speedDiv

    function automatic logic refPick(input logic io5, input logic io6, input logic [3:0] t);
        case ({io5, io6})
            2'h2: refPick = t[1];
            2'h1: refPick = t[2];
            2'h3: refPick = t[3];
            default: refPick = t[0];
        endcase
    endfunction : refPick

    function automatic logic parBit(input logic [7:0] d, input logic [1:0] lc, input logic even);
        logic p;
        p = ^(d & (8'hff >> (2'h3 - lc)));
        parBit = even ? p : ~p;
    endfunction : parBit

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [11:0] cmd1_ff, cmd2_ff, cmd3_ff, cmd4_ff;
    logic [31:0] prdata_ff;
    logic pready_ff, pslverr_ff;
    logic [7:0] txHold_ff, txShift_ff, rxShift_ff, rxData_ff;
    logic txFull_ff, txPar_ff, txd_ff, oddWant_ff, statPend_ff;
    logic rxAvail_ff, rxPerr_ff, rxFerr_ff, rxOvr_ff, rxPar_ff, rxDone_ff, rxStopBit_ff;
    logic [4:0] txCnt_ff, rxDivCnt_ff, txDivCnt_ff;
    logic [3:0] rxCnt_ff;
    logic [2:0] txBit_ff, rxBit_ff;
    alc_ser_state_type txState_ff, rxState_ff;
    alc_mdm_in_type prevIn_ff;
    alc_mdm_out_type mdm_ff;

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    wire logic apbDone = psel && penable && pready_ff;
    wire logic wrDone = apbDone && pwrite;
    wire logic rdDone = apbDone && !pwrite;
    wire logic hdrOk = pwdata[HDR_HI:HDR_LO] == CMD_HDR;
    wire logic isCmd = paddr == ADDR_CMD1 || paddr == ADDR_CMD2 || paddr == ADDR_CMD3 || paddr == ADDR_CMD4;
    wire logic mapped = isCmd || paddr == ADDR_TXD || paddr == ADDR_RXD || paddr == ADDR_STAT;
    wire logic badAcc = !mapped || (pwrite && isCmd && !hdrOk);
    // RULE7 header check
    wire logic cmdWr = wrDone && isCmd && hdrOk;
    wire logic txdWr = wrDone && paddr == ADDR_TXD;
    wire logic rxdRd = rdDone && paddr == ADDR_RXD;
    wire logic statRd = rdDone && paddr == ADDR_STAT;

    // RULE24 all-zero clear
    wire logic cmdClear = cmd1_ff[IO_HI:IO_LO] == 8'h00 && cmd2_ff[IO_HI:IO_LO] == 8'h00;
    wire logic txEn = cmd1_ff[C1_TXEN] && !cmdClear;
    wire logic rxEn = cmd1_ff[C1_RXEN] && !cmdClear;
    wire logic input_supervision_enable = cmd2_ff[C2_INPUT_SUPERVISION_ENABLE] && !cmdClear;
    wire logic evenPar = cmd3_ff[C3_PSEL];
    wire logic parEn = !cmd3_ff[C3_PDIS];
    wire logic [1:0] lenCode = {cmd3_ff[C3_LEN_HI], cmd3_ff[C3_LEN_LO]};
    wire logic [2:0] lastBit = 3'(3'h4 + 3'(lenCode));
    wire logic loopOn = cmd3_ff[C3_LOOP];
    wire logic echoOn = cmd3_ff[C3_ECHO];

    // RULE13 line loopback
    wire logic rxdEff = loopOn ? txd_ff : rxdIn;
    // RULE14 control loopback, modem inputs ignored
    alc_mdm_in_type inEff;
    assign inEff = loopOn ? alc_mdm_in_type'({mdm_ff.rts, mdm_ff.dtr, mdm_ff.lma, mdm_ff.secondary_request_line, mdm_ff.tb, 1'b0})
                          : mdmIn;

    // ----------------------------------------
    // Baud generators
    // ----------------------------------------
    // RULE1 speed field to divisor
    // RULE5 independent directions
    wire logic [4:0] rxDiv = speedDiv(cmd4_ff[C4_RX_HI:C4_RX_LO]);
    wire logic [4:0] txDiv = speedDiv(cmd4_ff[C4_TX_HI:C4_TX_LO]);
    // RULE4 reference selection
    wire logic rxRef = refPick(cmd2_ff[C2_RXR0], cmd2_ff[C2_RXR1], refTick);
    wire logic txRef = refPick(cmd2_ff[C2_TXR0], cmd2_ff[C2_TXR1], refTick);
    // RULE2 divide reference, then 16 sub-ticks per bit
    wire logic rxTick = rxRef && rxDivCnt_ff == 5'(rxDiv - 5'h01);
    wire logic txTick = txRef && txDivCnt_ff == 5'(txDiv - 5'h01);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rxDivCnt_ff <= 5'h00;
            txDivCnt_ff <= 5'h00;
        end else begin
            if (rxRef) rxDivCnt_ff <= rxTick ? 5'h00 : 5'(rxDivCnt_ff + 5'h01);
            if (txRef) txDivCnt_ff <= txTick ? 5'h00 : 5'(txDivCnt_ff + 5'h01);
        end
    end

    // ----------------------------------------
    // APB slave and command words
    // ----------------------------------------
    // RULE18 restraint masks the visible demand bit
    wire logic [31:0] rdMux =
        paddr == ADDR_CMD1 ? 32'(cmd1_ff) :
        paddr == ADDR_CMD2 ? 32'(cmd2_ff) :
        paddr == ADDR_CMD3 ? 32'(cmd3_ff) :
        paddr == ADDR_CMD4 ? 32'(cmd4_ff) :
        paddr == ADDR_RXD ? 32'(rxData_ff) :
        paddr == ADDR_STAT ? 32'({inEff, statPend_ff && input_supervision_enable, rxOvr_ff, rxFerr_ff, rxPerr_ff,
                                  rxAvail_ff, oddWant_ff && !inEff.restraint}) : 32'h0;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0;
        end else begin
            pready_ff <= psel && penable && !pready_ff;
            pslverr_ff <= psel && penable && !pready_ff && badAcc;
            if (psel && penable && !pready_ff) prdata_ff <= rdMux;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cmd1_ff <= 12'h000;
            cmd2_ff <= 12'h000;
            cmd3_ff <= 12'h000;
            cmd4_ff <= 12'h000;
        end else if (cmdWr) begin
            // RULE15 word four holds both speed fields
            case (paddr)
                ADDR_CMD1: cmd1_ff <= pwdata[11:0];
                ADDR_CMD2: cmd2_ff <= pwdata[11:0] & ~(12'h001 << C2_ISR);
                ADDR_CMD3: cmd3_ff <= pwdata[11:0];
                default: cmd4_ff <= pwdata[11:0];
            endcase
        end
    end

    // ----------------------------------------
    // Modem control and status
    // ----------------------------------------
    wire logic ctsRise = inEff.cts && !prevIn_ff.cts && txEn && cmd1_ff[C1_RTS];
    wire logic isrHit = cmdWr && paddr == ADDR_CMD2 && pwdata[C2_ISR] && (pwdata[C2_INPUT_SUPERVISION_ENABLE] || input_supervision_enable);
    // RULE23 carrier and data set ready report
    wire logic statEvt = (inEff.dcd && !prevIn_ff.dcd) || (inEff.dsr && !prevIn_ff.dsr) || ctsRise || isrHit;
    wire logic txLoad = txState_ff == SER_IDLE && txTick && txFull_ff && txEn && inEff.cts;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prevIn_ff <= '0;
            mdm_ff <= '0;
            // RULE21 power-up status stands pending until first reported
            statPend_ff <= 1'b1;
            oddWant_ff <= 1'b0;
        end else begin
            prevIn_ff <= inEff;
            mdm_ff <= '{rts: cmd1_ff[C1_RTS], secondary_request_line: cmd1_ff[C1_SECONDARY_REQUEST_LINE], om: cmd1_ff[C1_OM],
                        lma: cmd1_ff[C1_LMA], dtr: cmd1_ff[C1_DTR], tb: cmd1_ff[C1_TB]};
            // RULE21 read of reported status clears it; a new event wins
            statPend_ff <= statEvt || (statPend_ff && !(statRd && input_supervision_enable));
            // RULE16 first demand on clear to send
            // RULE17 demand on each buffer move
            // RULE24 demands dropped without output on
            if (!txEn) oddWant_ff <= 1'b0;
            else oddWant_ff <= ctsRise || txLoad || (oddWant_ff && !txdWr);
        end
    end

    // ----------------------------------------
    // Transmitter
    // ----------------------------------------
    // RULE11 stop length
    wire logic [4:0] stopTicks = !cmd3_ff[C3_STOP] ? TICKS_BIT : lenCode == 2'h0 ? TICKS_STOP15 : TICKS_STOP2;
    wire logic [4:0] txLimit = txState_ff == SER_STOP ? stopTicks : TICKS_BIT;
    wire logic txEnd = txTick && txCnt_ff == 5'(txLimit - 5'h01);
    wire logic lineBit = txState_ff == SER_START ? 1'b0 : txState_ff == SER_DATA ? txShift_ff[0] :
                         txState_ff == SER_PAR ? txPar_ff : 1'b1;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            txState_ff <= SER_IDLE;
            txCnt_ff <= 5'h00;
            txBit_ff <= 3'h0;
            txShift_ff <= 8'h00;
            txHold_ff <= 8'h00;
            txFull_ff <= 1'b0;
            txPar_ff <= 1'b0;
            txd_ff <= 1'b1;
        end else begin
            // RULE12 echo resends the received line
            txd_ff <= cmd2_ff[C2_BRK] ? 1'b0 : echoOn ? rxdEff : lineBit;
            if (txdWr) txHold_ff <= pwdata[7:0];
            txFull_ff <= txdWr || (txFull_ff && !txLoad && !cmdClear);
            if (txTick && txState_ff != SER_IDLE) txCnt_ff <= txEnd ? 5'h00 : 5'(txCnt_ff + 5'h01);
            case (txState_ff)
                SER_IDLE: if (txLoad) begin
                    txShift_ff <= txHold_ff;
                    // RULE8 parity sense
                    txPar_ff <= parBit(txHold_ff, lenCode, evenPar);
                    txCnt_ff <= 5'h00;
                    txState_ff <= SER_START;
                end
                SER_START: if (txEnd) begin
                    txBit_ff <= 3'h0;
                    txState_ff <= SER_DATA;
                end
                SER_DATA: if (txEnd) begin
                    txShift_ff <= txShift_ff >> 1;
                    txBit_ff <= 3'(txBit_ff + 3'h1);
                    // RULE9 parity appended only when enabled
                    if (txBit_ff == lastBit) txState_ff <= parEn ? SER_PAR : SER_STOP;
                end
                SER_PAR: if (txEnd) txState_ff <= SER_STOP;
                SER_STOP: if (txEnd) txState_ff <= SER_IDLE;
                default: txState_ff <= SER_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // Receiver
    // ----------------------------------------
    // RULE6 mid-bit sampling leaves margin for heavy distortion
    wire logic rxSample = rxTick && rxCnt_ff == TICK_LAST;
    // RULE10 align short characters to bit 0
    wire logic [7:0] rxAligned = rxShift_ff >> (2'h3 - lenCode);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rxState_ff <= SER_IDLE;
            rxCnt_ff <= 4'h0;
            rxBit_ff <= 3'h0;
            rxShift_ff <= 8'h00;
            rxPar_ff <= 1'b0;
            rxStopBit_ff <= 1'b1;
            rxDone_ff <= 1'b0;
        end else begin
            rxDone_ff <= 1'b0;
            if (rxTick) rxCnt_ff <= 4'(rxCnt_ff + 4'h1);
            case (rxState_ff)
                SER_IDLE: if (rxTick && !rxdEff) begin
                    rxCnt_ff <= 4'h0;
                    rxState_ff <= SER_START;
                end
                SER_START: if (rxTick && rxCnt_ff == TICK_MID) begin
                    rxCnt_ff <= 4'h0;
                    rxBit_ff <= 3'h0;
                    rxState_ff <= rxdEff ? SER_IDLE : SER_DATA;
                end
                SER_DATA: if (rxSample) begin
                    rxShift_ff <= {rxdEff, rxShift_ff[7:1]};
                    rxBit_ff <= 3'(rxBit_ff + 3'h1);
                    if (rxBit_ff == lastBit) rxState_ff <= parEn ? SER_PAR : SER_STOP;
                end
                SER_PAR: if (rxSample) begin
                    rxPar_ff <= rxdEff;
                    rxState_ff <= SER_STOP;
                end
                SER_STOP: if (rxSample) begin
                    rxStopBit_ff <= rxdEff;
                    rxDone_ff <= 1'b1;
                    rxState_ff <= SER_IDLE;
                end
                default: rxState_ff <= SER_IDLE;
            endcase
        end
    end

    // RULE22 delivery gated by receive enable
    wire logic rxDeliver = rxDone_ff && rxEn;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rxData_ff <= 8'h00;
            rxAvail_ff <= 1'b0;
            rxPerr_ff <= 1'b0;
            rxFerr_ff <= 1'b0;
            rxOvr_ff <= 1'b0;
        end else begin
            rxAvail_ff <= rxDeliver || (rxAvail_ff && !rxdRd && !cmdClear);
            if (rxDeliver) begin
                rxData_ff <= rxAligned;
                // RULE9 check only when enabled
                rxPerr_ff <= parEn && rxPar_ff != parBit(rxAligned, lenCode, evenPar);
                rxFerr_ff <= !rxStopBit_ff;
                rxOvr_ff <= rxAvail_ff && !rxdRd;
            end
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign txdOut = txd_ff;
    assign mdmOut = mdm_ff;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_top_speed: // RULE3
    assert property (cmd4_ff[C4_RX_HI:C4_RX_LO] == 4'hf |-> rxDiv == 5'h01 && txDiv != 5'h00)
        else $error("all-ones speed field must divide by one");
    a_low_speed: // RULE1
    assert property (cmd4_ff[C4_TX_HI:C4_TX_LO] == 4'h0 |-> txDiv == TICKS_BIT)
        else $error("all-zero speed field must divide by sixteen");
    a_apb_wait: // local APB decision
    assert property (psel && penable && !pready_ff |=> pready_ff ##1 !pready_ff)
        else $error("apb answer must come after exactly one wait");
    a_loop_cts: // RULE13
    assert property (loopOn |-> inEff.cts == mdm_ff.rts && rxdEff == txd_ff)
        else $error("loopback must tie request to clear and data to data");
    a_odd_load: // RULE17
    assert property (txLoad && txEn |=> oddWant_ff && txState_ff == SER_START)
        else $error("buffer move must raise a demand");
    a_odd_clear: // RULE24
    assert property (cmdClear |=> !oddWant_ff)
        else $error("cleared adapter must not demand data");
    a_rx_gate: // RULE22
    assert property ($rose(rxAvail_ff) |-> $past(rxEn) && $past(rxDone_ff))
        else $error("character delivered while receive disabled");
    sequence s_start_bit;
        txState_ff == SER_START && !echoOn && !cmd2_ff[C2_BRK];
    endsequence
    a_tx_start: // RULE11
    assert property (s_start_bit ##1 s_start_bit |-> !txd_ff)
        else $error("start bit must be spacing");
    a_stop_mark: // RULE11
    assert property (txState_ff == SER_STOP && !echoOn && !cmd2_ff[C2_BRK] |=> txd_ff)
        else $error("stop bit must be marking");
endmodule : alc_line_adapter

`default_nettype wire

// ===== alc_pkg.sv
// Package for the async line adapter: register map, command fields, states
package alc_pkg;
    // ----------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] ADDR_CMD1 = 8'h00;
    localparam logic [7:0] ADDR_CMD2 = 8'h04;
    localparam logic [7:0] ADDR_CMD3 = 8'h08;
    localparam logic [7:0] ADDR_CMD4 = 8'h0c;
    localparam logic [7:0] ADDR_TXD = 8'h10;
    localparam logic [7:0] ADDR_RXD = 8'h14;
    localparam logic [7:0] ADDR_STAT = 8'h18;
    // ----------------------------------------
    // Command cell fields
    // ----------------------------------------
    localparam logic [2:0] CMD_HDR = 3'h5;
    localparam int HDR_LO = 1;
    localparam int HDR_HI = 3;
    localparam int IO_LO = 4;
    localparam int IO_HI = 11;
    localparam int C1_RTS = 4, C1_SECONDARY_REQUEST_LINE = 5, C1_OM = 6, C1_LMA = 7;
    localparam int C1_DTR = 8, C1_TB = 9, C1_RXEN = 10, C1_TXEN = 11;
    localparam int C2_BRK = 4, C2_ISR = 5, C2_INPUT_SUPERVISION_ENABLE = 6;
    localparam int C2_RXR0 = 8, C2_RXR1 = 9, C2_TXR0 = 10, C2_TXR1 = 11;
    localparam int C3_PSEL = 4, C3_PDIS = 5, C3_LEN_LO = 6, C3_LEN_HI = 7;
    localparam int C3_STOP = 8, C3_ECHO = 10, C3_LOOP = 11;
    localparam int C4_RX_LO = 4, C4_RX_HI = 7, C4_TX_LO = 8, C4_TX_HI = 11;
    // ----------------------------------------
    // Bit timing in 16x sub-ticks
    // ----------------------------------------
    localparam logic [4:0] TICKS_BIT = 5'h10;
    localparam logic [4:0] TICKS_STOP15 = 5'h18;
    localparam logic [4:0] TICKS_STOP2 = 5'h20;
    localparam logic [3:0] TICK_MID = 4'h7;
    localparam logic [3:0] TICK_LAST = 4'hf;
    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef struct packed {
        logic rts, secondary_request_line, om, lma, dtr, tb;
    } alc_mdm_out_type;
    typedef struct packed {
        logic cts, dsr, dcd, sdcd, ri, restraint;
    } alc_mdm_in_type;
    typedef enum logic [4:0] {
        SER_IDLE = 5'h01, SER_START = 5'h02, SER_DATA = 5'h04,
        SER_PAR = 5'h08, SER_STOP = 5'h10
    } alc_ser_state_type;
endpackage : alc_pkg

// ===== alc_modem_model.sv
// Far-side modem model: delayed clear to send, line echo from a remote terminal
`timescale 1ns/100ps
`default_nettype none
module alc_modem_model
    import alc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic txdOut,
    input wire alc_mdm_out_type mdmOut,
    input wire logic restrainIn,
    input wire logic lineSel,
    input wire logic farBit,
    output logic rxdIn,
    output alc_mdm_in_type mdmIn
);
    logic [3:0] ctsDly_ff;
    logic echo_ff;
    // A slow modem answers request to send only after a few cycles
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctsDly_ff <= 4'h0;
            echo_ff <= 1'b1;
        end else begin
            ctsDly_ff <= {ctsDly_ff[2:0], mdmOut.rts};
            echo_ff <= txdOut;
        end
    end
    // The far end either echoes our line or drives its own level
    assign rxdIn = lineSel ? farBit : echo_ff;
    assign mdmIn = '{cts: ctsDly_ff[3], dsr: mdmOut.dtr, dcd: mdmOut.dtr, sdcd: 1'b0, ri: 1'b0,
                     restraint: restrainIn};
endmodule : alc_modem_model
`default_nettype wire

// ===== tb_alc_line_adapter.sv
// Testbench for the async line adapter: APB command sequences and line checks
`timescale 1ns/100ps
`default_nettype none
module tb_alc_line_adapter;
    import alc_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, restrainIn = 1'b0;
    logic lineSel = 1'b0, farBit = 1'b1;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, txdOut, rxdIn, err;
    logic [4:0] tickCnt = 5'h00;
    logic [3:0] refTick;
    alc_mdm_in_type mdmIn;
    alc_mdm_out_type mdmOut;
    int nErrors = 0, cmpCount = 0;
    always #2.5 clk = ~clk;
    // Reference pulses: the 153.6k slot fires every other cycle to keep runs short
    always @(posedge clk) tickCnt <= tickCnt + 5'h01;
    assign refTick = {tickCnt[2:0] == 3'h0, tickCnt[0], tickCnt[3:0] == 4'h0, tickCnt == 5'h00};
    alc_line_adapter i_alc_line_adapter (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .refTick(refTick), .rxdIn(rxdIn), .mdmIn(mdmIn), .txdOut(txdOut),
        .mdmOut(mdmOut));
    alc_modem_model i_alc_modem_model (.clk(clk), .rst(rst), .txdOut(txdOut), .mdmOut(mdmOut),
        .restrainIn(restrainIn), .lineSel(lineSel), .farBit(farBit), .rxdIn(rxdIn), .mdmIn(mdmIn));
    // ----------------------------------------
    // Bus and compare tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmpCount++;
        if (got !== exp) begin
            nErrors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    // Entered just after a rising edge; psel drops for a cycle between transfers
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        if (n >= 50) check(32'h0, 32'h1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic wr(input logic [7:0] addr, input logic [31:0] data);
        apb(1'b1, addr, data);
        check({31'h0, err}, 32'h0);
    endtask : wr
    task automatic rdchk(input logic [7:0] addr, input logic [31:0] mask, input logic [31:0] exp);
        apb(1'b0, addr, 32'h0);
        check(rd & mask, exp);
    endtask : rdchk
    task automatic poll(input logic [31:0] mask);
        int n;
        n = 0;
        do begin
            apb(1'b0, ADDR_STAT, 32'h0);
            n++;
        end while ((rd & mask) !== mask && n < 3000);
        check(rd & mask, mask);
    endtask : poll
    // Length of the first low run on the transmit line, in clock cycles
    task automatic low_run(input int exp);
        int n;
        n = 0;
        while (txdOut !== 1'b0 && n < 20000) begin
            @(posedge clk);
            n++;
        end
        n = 0;
        while (txdOut === 1'b0 && n < 20000) begin
            @(posedge clk);
            n++;
        end
        check(n, exp);
    endtask : low_run
    task automatic end_of_test;
        $display("compares=%0d mismatches=%0d", cmpCount, nErrors);
        if (nErrors == 0 && cmpCount > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_of_test
    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        wr(ADDR_CMD1, 32'h00a);
        wr(ADDR_CMD2, 32'h00a);
        wr(ADDR_CMD3, 32'h00a);
        wr(ADDR_CMD2, 32'h04a);
        rdchk(ADDR_STAT, 32'h021, 32'h020);
        rdchk(ADDR_STAT, 32'h020, 32'h000);
        apb(1'b0, 8'h1c, 32'h0);
        check({err, rd[30:0]}, 32'h80000000);
        apb(1'b1, ADDR_CMD3, 32'h004);
        check({31'h0, err}, 32'h1);
        // Loopback at full 9600 rate: one bit is 16 pulses two cycles apart
        restrainIn <= 1'b1;
        wr(ADDR_CMD2, 32'ha4a);
        wr(ADDR_CMD4, 32'hffa);
        wr(ADDR_CMD3, 32'h8ea);
        wr(ADDR_CMD1, 32'hfba);
        repeat (10) @(posedge clk);
        check({26'h0, mdmOut}, 32'h37);
        rdchk(ADDR_STAT, 32'hfc1, 32'hf81);
        restrainIn <= 1'b0;
        wr(ADDR_TXD, 32'h096);
        low_run(64);
        rdchk(ADDR_STAT, 32'h001, 32'h001);
        poll(32'h002);
        rdchk(ADDR_RXD, 32'hff, 32'h96);
        // Real modem with echoing far end: even parity, 7 bits, two stops, slowest speed
        wr(ADDR_CMD3, 32'h19a);
        wr(ADDR_CMD4, 32'h00a);
        // Drop output, request and ready first so the next enable brings real rising edges
        wr(ADDR_CMD1, 32'h40a);
        repeat (10) @(posedge clk);
        rdchk(ADDR_STAT, 32'he21, 32'h000);
        wr(ADDR_CMD1, 32'hd1a);
        repeat (10) @(posedge clk);
        rdchk(ADDR_STAT, 32'hfe1, 32'he21);
        restrainIn <= 1'b1;
        rdchk(ADDR_STAT, 32'h041, 32'h040);
        restrainIn <= 1'b0;
        rdchk(ADDR_STAT, 32'h001, 32'h001);
        wr(ADDR_TXD, 32'h055);
        low_run(512);
        poll(32'h002);
        rdchk(ADDR_STAT, 32'h01c, 32'h000);
        rdchk(ADDR_RXD, 32'h7f, 32'h55);
        // Echo with the far end driving the line: a 40-cycle space must come straight back
        wr(ADDR_CMD3, 32'h59a);
        lineSel <= 1'b1;
        fork
            low_run(40);
            begin
                farBit <= 1'b0;
                repeat (40) @(posedge clk);
                farBit <= 1'b1;
            end
        join
        lineSel <= 1'b0;
        wr(ADDR_CMD1, 32'h00a);
        rdchk(ADDR_STAT, 32'h001, 32'h000);
        end_of_test();
    end
    initial begin
        #250000;
        nErrors++;
        end_of_test();
    end
endmodule : tb_alc_line_adapter
`default_nettype wire
